// ==== verilog/rrpx_regs.sv ====
// Signal strength, amplifier bias and crystal trim register bank

// Summary of operation
// - The signal-strength register is wholly read-only and its bits 7:6 read zero.
// - Bit 5 of the signal-strength register reads 1 only while bits 4:0 hold a valid sample.
// - Bits 4:0 report received strength, a larger value meaning a stronger signal.
// - One strength sample is caught per entry into receive mode, set by writing bit 7 of address 0x03 as 1.
// - The bias field in bits 2:0 takes 0 to 7, higher meaning more transmit power.
// - Crystal trim bit 6 set stops the reference clock output; clear lets it drive.
// - After reset the clock output disable bit is clear, so the clock output is on.
// - Crystal trim bits 5:0 set the load capacitance trim, one step per increment.
// - Writing the self-clearing device reset bit restores every register here to default.
module rrpx_regs (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       spi_sck,
	input  wire logic       spi_ss_n,
	input  wire logic       spi_mosi,
	output logic            spi_miso,
	output logic            spi_miso_oe,
	input  wire logic [4:0] strength_sample,
	input  wire logic       strength_sample_strobe,
	output logic            receive_mode,
	output logic [2:0]      amplifier_bias_field,
	output logic [5:0]      crystal_trim_field,
	output logic            reference_clock_output_enable
);

	logic [5:0] addr;
	logic [7:0] rd_data;
	logic       wr_strobe;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;

	logic [4:0] strength_value,   next_strength_value;
	logic       strength_valid,   next_strength_valid;
	logic       capture_armed,    next_capture_armed;
	logic       next_receive_mode;
	logic [2:0] next_amplifier_bias_field;
	logic [5:0] next_crystal_trim_field;
	logic       clock_out_disable, next_clock_out_disable;
	logic       next_ref_out_enable;
	logic       soft_reset,       next_soft_reset;
	logic       bank_reset;

	logic [7:0] strength_view;
	logic [7:0] bias_view;
	logic [7:0] trim_view;
	logic       hit_control;
	logic       hit_analog;

	// ------------------------------------------------------------
	// Serial port
	// ------------------------------------------------------------
	rrpx_spi_slave u_spi (
		.clk         (clk),
		.reset       (reset),
		.spi_sck     (spi_sck),
		.spi_ss_n    (spi_ss_n),
		.spi_mosi    (spi_mosi),
		.spi_miso    (spi_miso),
		.spi_miso_oe (spi_miso_oe),
		.addr        (addr),
		.rd_data     (rd_data),
		.wr_strobe   (wr_strobe),
		.wr_addr     (wr_addr),
		.wr_data     (wr_data)
	);

	// ------------------------------------------------------------
	// Read views
	// ------------------------------------------------------------
	// Reserved bits are not stored and read zero
	always_comb begin
		strength_view = rrpx_pkg::READ_ZERO;
		strength_view[rrpx_pkg::STRENGTH_VALID_BIT] = strength_valid;
		strength_view[rrpx_pkg::STRENGTH_MSB:0] = strength_value;
		bias_view = rrpx_pkg::READ_ZERO;
		bias_view[rrpx_pkg::BIAS_MSB:0] = amplifier_bias_field;
		trim_view = rrpx_pkg::READ_ZERO;
		trim_view[rrpx_pkg::CLOCK_OUT_DIS_BIT] = clock_out_disable;
		trim_view[rrpx_pkg::TRIM_MSB:0] = crystal_trim_field;
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// Unmapped and write-only addresses read zero
	always_comb begin
		rd_data = rrpx_pkg::READ_ZERO;
		unique case (addr)
			rrpx_pkg::ADDR_SIGNAL_STRENGTH_STATUS: begin
				rd_data = strength_view;
			end
			rrpx_pkg::ADDR_AMPLIFIER_BIAS_SETTING: begin
				rd_data = bias_view;
			end
			rrpx_pkg::ADDR_CRYSTAL_TRIM_AND_CLOCK_OUT: begin
				rd_data = trim_view;
			end
			default: begin
				rd_data = rrpx_pkg::READ_ZERO;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	// Neither target is readable here; both act only on the write
	always_comb begin
		hit_control = wr_strobe & (wr_addr == rrpx_pkg::ADDR_CONTROL);
		hit_analog  = wr_strobe &
			(wr_addr == rrpx_pkg::ADDR_ANALOG_CONTROL);
	end

	// ------------------------------------------------------------
	// Device reset
	// ------------------------------------------------------------
	// Pulse lasts one clock, then the bit reads back as clear
	always_comb begin
		next_soft_reset = hit_analog & ~soft_reset &
			wr_data[rrpx_pkg::DEVICE_RESET_BIT];
		bank_reset = reset | soft_reset;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= next_soft_reset;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_comb begin
		next_amplifier_bias_field = amplifier_bias_field;
		next_crystal_trim_field   = crystal_trim_field;
		next_clock_out_disable    = clock_out_disable;
		if (wr_strobe) begin
			unique case (wr_addr)
				rrpx_pkg::ADDR_AMPLIFIER_BIAS_SETTING: begin
					// Bits 7:3 are not stored and read zero
					next_amplifier_bias_field =
						wr_data[rrpx_pkg::BIAS_MSB:0];
				end
				rrpx_pkg::ADDR_CRYSTAL_TRIM_AND_CLOCK_OUT: begin
					next_crystal_trim_field =
						wr_data[rrpx_pkg::TRIM_MSB:0];
					next_clock_out_disable =
						wr_data[rrpx_pkg::CLOCK_OUT_DIS_BIT];
				end
				default: begin
					next_amplifier_bias_field = amplifier_bias_field;
				end
			endcase
		end
		next_ref_out_enable = ~next_clock_out_disable;
	end

	always_ff @(posedge clk) begin
		if (bank_reset) begin
			amplifier_bias_field          <= rrpx_pkg::BIAS_RESET;
			crystal_trim_field            <= rrpx_pkg::TRIM_RESET;
			clock_out_disable             <= rrpx_pkg::CLOCK_OUT_DIS_RESET;
			reference_clock_output_enable <= ~rrpx_pkg::CLOCK_OUT_DIS_RESET;
		end else begin
			amplifier_bias_field          <= next_amplifier_bias_field;
			crystal_trim_field            <= next_crystal_trim_field;
			clock_out_disable             <= next_clock_out_disable;
			reference_clock_output_enable <= next_ref_out_enable;
		end
	end

	// ------------------------------------------------------------
	// Receive mode and strength capture
	// ------------------------------------------------------------
	// Stored value changes only by capture or device reset; writes to its address never reach it
	always_comb begin
		next_receive_mode   = receive_mode;
		next_capture_armed  = capture_armed;
		next_strength_value = strength_value;
		next_strength_valid = strength_valid;
		if (capture_armed & strength_sample_strobe) begin
			next_strength_value = strength_sample;
			next_strength_valid = 1'b1;
			next_capture_armed  = 1'b0;
		end
		// Entry wins over a sample strobe in the same clock
		if (hit_control) begin
			next_receive_mode = wr_data[rrpx_pkg::RX_ENABLE_BIT];
			if (wr_data[rrpx_pkg::RX_ENABLE_BIT] & ~receive_mode) begin
				// Fresh entry: old sample no longer describes this one
				next_capture_armed  = 1'b1;
				next_strength_valid = 1'b0;
			end else if (~wr_data[rrpx_pkg::RX_ENABLE_BIT]) begin
				next_capture_armed = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (bank_reset) begin
			receive_mode   <= 1'b0;
			capture_armed  <= 1'b0;
			strength_value <= rrpx_pkg::STRENGTH_RESET;
			strength_valid <= 1'b0;
		end else begin
			receive_mode   <= next_receive_mode;
			capture_armed  <= next_capture_armed;
			strength_value <= next_strength_value;
			strength_valid <= next_strength_valid;
		end
	end

endmodule

// ==== verilog/rrpx_pkg.sv ====
// Package: addresses, field layouts, reset values and framing of the bank
package rrpx_pkg;

	// ------------------------------------------------------------
	// Serial framing
	// ------------------------------------------------------------
	localparam int unsigned HDR_WRITE_BIT   = 7;
	localparam int unsigned HDR_INC_BIT     = 6;
	localparam logic [2:0]  LAST_BIT_INDEX  = 3'h7;
	localparam logic [5:0]  ADDR_STEP       = 6'h01;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_CONTROL                    = 6'h03;
	localparam logic [5:0] ADDR_ANALOG_CONTROL             = 6'h20;
	localparam logic [5:0] ADDR_SIGNAL_STRENGTH_STATUS     = 6'h22;
	localparam logic [5:0] ADDR_AMPLIFIER_BIAS_SETTING     = 6'h23;
	localparam logic [5:0] ADDR_CRYSTAL_TRIM_AND_CLOCK_OUT = 6'h24;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned RX_ENABLE_BIT       = 7;
	localparam int unsigned DEVICE_RESET_BIT    = 0;
	localparam int unsigned STRENGTH_VALID_BIT  = 5;
	localparam int unsigned STRENGTH_MSB        = 4;
	localparam int unsigned BIAS_MSB            = 2;
	localparam int unsigned CLOCK_OUT_DIS_BIT   = 6;
	localparam int unsigned TRIM_MSB            = 5;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [4:0] STRENGTH_RESET      = 5'h00;
	localparam logic [2:0] BIAS_RESET          = 3'h0;
	localparam logic [5:0] TRIM_RESET          = 6'h00;
	localparam logic       CLOCK_OUT_DIS_RESET = 1'b0;
	localparam logic [7:0] READ_ZERO           = 8'h00;

endpackage

// ==== verilog/rrpx_spi_slave.sv ====
// Serial byte engine: header decode, address stepping, read and write strobes
module rrpx_spi_slave (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       spi_sck,
	input  wire logic       spi_ss_n,
	input  wire logic       spi_mosi,
	output logic            spi_miso,
	output logic            spi_miso_oe,
	output logic [5:0]      addr,
	input  wire logic [7:0] rd_data,
	output logic            wr_strobe,
	output logic [5:0]      wr_addr,
	output logic [7:0]      wr_data
);

	logic       sck_prev,  next_sck_prev;
	logic [2:0] bit_cnt,   next_bit_cnt;
	logic [6:0] rx_shift,  next_rx_shift;
	logic [7:0] tx_shift,  next_tx_shift;
	logic       in_hdr,    next_in_hdr;
	logic       is_write,  next_is_write;
	logic       auto_inc,  next_auto_inc;
	logic       load_pend, next_load_pend;
	logic [5:0] next_addr;
	logic       next_spi_miso;
	logic       next_spi_miso_oe;
	logic       next_wr_strobe;
	logic [5:0] next_wr_addr;
	logic [7:0] next_wr_data;
	logic       sck_rise;
	logic       sck_fall;
	logic [7:0] byte_in;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		sck_rise         = spi_sck & ~sck_prev & ~spi_ss_n;
		sck_fall         = ~spi_sck & sck_prev & ~spi_ss_n;
		byte_in          = {rx_shift, spi_mosi};
		next_sck_prev    = spi_sck;
		next_bit_cnt     = bit_cnt;
		next_rx_shift    = rx_shift;
		next_tx_shift    = tx_shift;
		next_in_hdr      = in_hdr;
		next_is_write    = is_write;
		next_auto_inc    = auto_inc;
		next_load_pend   = 1'b0;
		next_addr        = addr;
		next_spi_miso    = spi_miso;
		next_spi_miso_oe = ~spi_ss_n;
		next_wr_strobe   = 1'b0;
		next_wr_addr     = wr_addr;
		next_wr_data     = wr_data;
		if (spi_ss_n) begin
			next_bit_cnt  = 3'h0;
			next_in_hdr   = 1'b1;
			next_tx_shift = rrpx_pkg::READ_ZERO;
			next_spi_miso = 1'b0;
		end else begin
			// Read data fetched one clock after the address settles
			if (load_pend) begin
				next_tx_shift = rd_data;
			end
			if (sck_rise) begin
				next_rx_shift = byte_in[6:0];
				next_bit_cnt  = bit_cnt + 3'h1;
				if (bit_cnt == rrpx_pkg::LAST_BIT_INDEX) begin
					if (in_hdr) begin
						next_in_hdr   = 1'b0;
						next_is_write = byte_in[rrpx_pkg::HDR_WRITE_BIT];
						next_auto_inc = byte_in[rrpx_pkg::HDR_INC_BIT];
						next_addr     = byte_in[5:0];
						next_load_pend = ~byte_in[rrpx_pkg::HDR_WRITE_BIT];
					end else begin
						if (is_write) begin
							next_wr_strobe = 1'b1;
							next_wr_addr   = addr;
							next_wr_data   = byte_in;
						end else begin
							next_load_pend = 1'b1;
						end
						if (auto_inc) begin
							next_addr = addr + rrpx_pkg::ADDR_STEP;
						end
					end
				end
			end
			if (sck_fall) begin
				next_spi_miso = tx_shift[7];
				next_tx_shift = {tx_shift[6:0], 1'b0};
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			sck_prev    <= 1'b0;
			bit_cnt     <= 3'h0;
			rx_shift    <= 7'h00;
			tx_shift    <= 8'h00;
			in_hdr      <= 1'b1;
			is_write    <= 1'b0;
			auto_inc    <= 1'b0;
			load_pend   <= 1'b0;
			addr        <= 6'h00;
			spi_miso    <= 1'b0;
			spi_miso_oe <= 1'b0;
			wr_strobe   <= 1'b0;
			wr_addr     <= 6'h00;
			wr_data     <= 8'h00;
		end else begin
			sck_prev    <= next_sck_prev;
			bit_cnt     <= next_bit_cnt;
			rx_shift    <= next_rx_shift;
			tx_shift    <= next_tx_shift;
			in_hdr      <= next_in_hdr;
			is_write    <= next_is_write;
			auto_inc    <= next_auto_inc;
			load_pend   <= next_load_pend;
			addr        <= next_addr;
			spi_miso    <= next_spi_miso;
			spi_miso_oe <= next_spi_miso_oe;
			wr_strobe   <= next_wr_strobe;
			wr_addr     <= next_wr_addr;
			wr_data     <= next_wr_data;
		end
	end

endmodule

// ==== verif/rrpx_monitor.sv ====
// Checker of the bank's pins: select, reset defaults, write-only changes
module rrpx_monitor (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       spi_ss_n,
	input wire logic       spi_miso,
	input wire logic       spi_miso_oe,
	input wire logic       receive_mode,
	input wire logic [2:0] amplifier_bias_field,
	input wire logic [5:0] crystal_trim_field,
	input wire logic       reference_clock_output_enable
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);

	a_reset_defaults: assert property (disable iff (1'b0)
		reset |=> !receive_mode && !spi_miso_oe &&
		amplifier_bias_field == 3'h0 && crystal_trim_field == 6'h00 &&
		reference_clock_output_enable)
		else $error("outputs off default after reset");
	a_oe_on_select: assert property ($fell(spi_ss_n) |=> spi_miso_oe)
		else $error("miso enable late");
	a_oe_off_idle: assert property (spi_ss_n [*2] |-> !spi_miso_oe)
		else $error("miso enable while idle");
	a_miso_idle_low: assert property (spi_ss_n [*2] |-> !spi_miso)
		else $error("miso high while idle");
	// Settings move only on a serial write, never between frames
	a_bias_by_write: assert property (
		$changed(amplifier_bias_field) |-> !$past(spi_ss_n))
		else $error("bias moved outside a frame");
	a_trim_by_write: assert property (
		!$stable(crystal_trim_field) |-> !$past(spi_ss_n))
		else $error("trim moved outside a frame");
	a_clkout_by_write: assert property (
		$rose(reference_clock_output_enable) ||
		$fell(reference_clock_output_enable) |-> !$past(spi_ss_n))
		else $error("clock output moved outside a frame");
	a_mode_by_write: assert property (
		$rose(receive_mode) |-> !$past(spi_ss_n, 2))
		else $error("receive mode entered outside a frame");
endmodule

bind rrpx_regs rrpx_monitor u_rrpx_monitor (
	.clk(clk), .reset(reset), .spi_ss_n(spi_ss_n), .spi_miso(spi_miso),
	.spi_miso_oe(spi_miso_oe), .receive_mode(receive_mode),
	.amplifier_bias_field(amplifier_bias_field),
	.crystal_trim_field(crystal_trim_field),
	.reference_clock_output_enable(reference_clock_output_enable)
);

// ==== verif/rrpx_host.sv ====
// Host controller model: mode 0 header plus one or more data bytes per frame
module rrpx_host (
	input  wire logic clk,
	output logic      spi_sck,
	output logic      spi_ss_n,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 4;
	initial begin
		spi_sck = 1'b0;
		spi_ss_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// Each clock phase spans four cycles; the block needs two
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spi_sck = 1'b0;
			spi_mosi = tx[i];
			repeat (HALF) @(negedge clk);
			rx[i] = spi_miso;
			spi_sck = 1'b1;
			repeat (HALF) @(negedge clk);
		end
	endtask
	task automatic begin_frame(input logic [7:0] hdr);
		logic [7:0] junk;
		@(negedge clk);
		spi_ss_n = 1'b0;
		shift(hdr, junk);
	endtask
	task automatic end_frame();
		spi_sck = 1'b0;
		repeat (HALF) @(negedge clk);
		spi_ss_n = 1'b1;
		// Released line must not keep showing the last bit
		spi_mosi = ~spi_mosi;
		repeat (HALF) @(negedge clk);
	endtask
	task automatic frame(input logic [7:0] hdr, input logic [7:0] d,
		output logic [7:0] rx);
		begin_frame(hdr);
		shift(d, rx);
		end_frame();
	endtask
endmodule

// ==== verif/rrpx_regs_tb.sv ====
// Self-checking bench for the strength, bias and trim bank
`define CHK(nm, e, s) \
	n_tests++; \
	if ((s) !== (e)) begin \
		errors++; \
		$display("[FAIL] %s exp %h seen %h", nm, e, s); \
	end
module rrpx_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        spi_sck, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe;
	logic        host_miso;
	logic [4:0]  strength_sample = 5'h00;
	logic        strength_sample_strobe = 1'b0;
	logic        receive_mode, reference_clock_output_enable;
	logic [2:0]  amplifier_bias_field;
	logic [5:0]  crystal_trim_field;
	logic [15:0] exp_q[$];
	string       nm_q[$];
	logic [15:0] seen;
	event        got;
	int          errors = 0;
	int          n_tests = 0;

	rrpx_regs u_rrpx_regs (
		.clk(clk), .reset(reset), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
		.strength_sample(strength_sample),
		.strength_sample_strobe(strength_sample_strobe),
		.receive_mode(receive_mode),
		.amplifier_bias_field(amplifier_bias_field),
		.crystal_trim_field(crystal_trim_field),
		.reference_clock_output_enable(reference_clock_output_enable)
	);
	rrpx_host u_rrpx_host (
		.clk(clk), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n),
		.spi_mosi(spi_mosi), .spi_miso(host_miso)
	);

	always #5 clk = ~clk;
	// Undriven output shows the inverse, so a missing enable spoils reads
	assign host_miso = spi_miso_oe ? spi_miso : ~spi_miso;

	always @(got) begin
		string nm;
		logic [15:0] e;
		nm = nm_q.pop_front();
		e = exp_q.pop_front();
		`CHK(nm, e, seen)
	end

	task automatic complete_run();
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic show(input string nm, input logic [15:0] e,
		input logic [15:0] v);
		nm_q.push_back(nm);
		exp_q.push_back(e);
		seen = v;
		-> got;
		#1;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] rx;
		u_rrpx_host.frame({2'b10, a}, d, rx);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] rx;
		u_rrpx_host.frame({2'b00, a}, 8'h00, rx);
		show("read", {8'h00, e}, {8'h00, rx});
	endtask
	task automatic pins(input logic [2:0] b, input logic [5:0] t,
		input logic en, input logic rm);
		show("pins", {5'h00, rm, en, b, t}, {5'h00, receive_mode,
			reference_clock_output_enable, amplifier_bias_field,
			crystal_trim_field});
	endtask
	task automatic strobe(input logic [4:0] s);
		@(negedge clk);
		strength_sample = s;
		strength_sample_strobe = 1'b1;
		@(negedge clk);
		strength_sample_strobe = 1'b0;
		strength_sample = ~s;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		complete_run();
	end

	initial begin
		logic [7:0] v, w;
		logic [4:0] s;
		void'($urandom(66));
		repeat (6) @(negedge clk);
		reset = 1'b0;
		pins(3'h0, 6'h00, 1'b1, 1'b0);
		for (int a = 6'h20; a < 6'h25; a++) rd(6'(a), 8'h00);
		wr(6'h22, 8'hFF);
		rd(6'h22, 8'h00);
		for (int b = 0; b < 8; b++) begin
			wr(6'h23, {5'h00, 3'(b)});
			rd(6'h23, {5'h00, 3'(b)});
		end
		pins(3'h7, 6'h00, 1'b1, 1'b0);
		repeat (4) begin
			v = {1'b0, 7'($urandom)};
			wr(6'h24, v);
			rd(6'h24, v);
			pins(3'h7, v[5:0], !v[6], 1'b0);
		end
		// Stepping header: bias then trim in one frame, read back likewise
		u_rrpx_host.begin_frame({2'b11, 6'h23});
		u_rrpx_host.shift(8'h07, v);
		u_rrpx_host.shift(8'h2A, v);
		u_rrpx_host.end_frame();
		pins(3'h7, 6'h2A, 1'b1, 1'b0);
		u_rrpx_host.begin_frame({2'b01, 6'h23});
		u_rrpx_host.shift(8'h00, v);
		u_rrpx_host.shift(8'h00, w);
		u_rrpx_host.end_frame();
		show("read", 16'h0007, {8'h00, v});
		show("read", 16'h002A, {8'h00, w});
		wr(6'h24, 8'h40);
		pins(3'h7, 6'h00, 1'b0, 1'b0);
		strobe(5'h1F);
		rd(6'h22, 8'h00);
		wr(6'h03, 8'h80);
		s = 5'($urandom);
		strobe(s);
		strobe(~s);
		rd(6'h22, {3'h1, s});
		pins(3'h7, 6'h00, 1'b0, 1'b1);
		wr(6'h03, 8'h00);
		wr(6'h03, 8'h80);
		strobe(5'h1F);
		wr(6'h03, 8'h80);
		strobe(5'h05);
		rd(6'h22, 8'h3F);
		wr(6'h20, 8'h01);
		pins(3'h0, 6'h00, 1'b1, 1'b0);
		for (int a = 6'h22; a < 6'h25; a++) rd(6'(a), 8'h00);
		complete_run();
	end
endmodule
